// ---- src/scr_pkg.sv ----
// constants for the system configuration control register bank
// assumes a 32-bit register port with byte offsets on an 8-bit address
package scr_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h04;
	localparam logic [7:0] OFS_PLL_CONTROL = 8'h0c;
	localparam logic [7:0] OFS_DEBUG_CONTROL = 8'h10;
	localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h18;
	localparam logic [7:0] OFS_CORE0_SECURE_VECTOR = 8'h20;
	localparam logic [7:0] OFS_CORE1_SECURE_VECTOR = 8'h28;
	localparam logic [7:0] OFS_PIN_MAIN_INPUT_SELECT = 8'h30;
	localparam logic [7:0] OFS_PIN_MAIN_OUTPUT_SELECT = 8'h34;
	localparam logic [7:0] OFS_PIN_MAIN_OE_SELECT = 8'h38;
	localparam logic [7:0] OFS_PIN_MAIN_DEFAULT_INPUT = 8'h3c;
	// writable bits per register; all others read as zero
	localparam logic [31:0] CLK_MASK = 32'h0000_f0ff;
	localparam logic [31:0] PLL_MASK = 32'h3fff_ff07;
	localparam logic [31:0] DBG_MASK = 32'h8000_07df;
	localparam logic [31:0] INT_MASK = 32'h0003_003f;
	localparam logic [31:0] VEC_MASK = 32'hffff_ff80;
	localparam logic [31:0] PIN_MASK = 32'h0000_ffff;
	// reset values
	localparam logic [31:0] CLK_RESET = 32'h0000_0027;
	localparam logic [31:0] PLL_RESET = 32'h0beb_0100;
	localparam logic [31:0] DBG_RESET = 32'h0000_001e;
	localparam logic [31:0] INT_RESET = 32'h0000_0002;
	localparam logic [24:0] VEC_FIELD_RESET = 25'h000_4000;
	localparam logic [31:0] VEC_RESET = {VEC_FIELD_RESET, 7'h00};
	localparam logic [31:0] PIN_SELECT_RESET = 32'h0000_ffff;
	localparam logic [31:0] PIN_DEFAULT_RESET = 32'h0000_0000;
	// clock control fields
	localparam int CLK_TEST_EN_BIT = 15;
	localparam int CLK_TEST_SEL_LSB = 12;
	localparam int CLK_PLL_IN_SEL_BIT = 7;
	localparam int CLK_CFG_SEL_BIT = 6;
	localparam int CLK_REF_EN_BIT = 5;
	localparam int CLK_REF_SEL_BIT = 4;
	localparam int CLK_CFG_EN_BIT = 3;
	localparam int CLK_MAIN_EN_BIT = 2;
	localparam int CLK_MAIN_SEL_LSB = 0;
	localparam logic [2:0] TEST_SEL_VCO = 3'h0;
	localparam logic [2:0] TEST_SEL_CORE = 3'h1;
	localparam logic [2:0] TEST_SEL_SYSTEM = 3'h2;
	localparam logic [2:0] TEST_SEL_CONFIG = 3'h5;
	localparam logic [1:0] MAIN_SEL_SLOW_REF = 2'h0;
	localparam logic [1:0] MAIN_SEL_RESERVED = 2'h1;
	// pll control fields
	localparam int PLL_FB_LSB = 16;
	localparam int PLL_POST2_LSB = 12;
	localparam int PLL_POST1_LSB = 8;
	localparam int PLL_POST1_OFF_BIT = 2;
	localparam int PLL_BYPASS_BIT = 1;
	localparam int PLL_OFF_BIT = 0;
	// debug and interrupt control fields
	localparam int DBG_FORCE_BIT = 31;
	localparam int DBG_FREQ_LSB = 6;
	localparam int INT_EXT_INV_BIT = 17;
	localparam int INT_EXT_EN_BIT = 16;
	localparam int INT_SRAM_CLR_BIT = 5;
	localparam int INT_SRAM_EN_BIT = 4;
	localparam int INT_QSPI_CLR_BIT = 3;
	localparam int INT_QSPI_EN_BIT = 2;
	localparam int INT_PERIPH_CLR_BIT = 1;
	localparam int INT_PERIPH_EN_BIT = 0;
	localparam int VEC_LSB = 7;
endpackage

// ---- src/scr_system_config_control_regs.sv ----
// system configuration control register bank with pin and debug muxing
// assumes one 125 MHz clock; pad and interrupt pins are asynchronous
// Behaviour
// - test clock select field picks vco, core, system or config clock; enable gates
// - pll input select bit routes config pad clock to pll reference at 0
// - config clock select picks config pad or fast pad clock; own enable bit
// - reference select picks slow pad reference or fast clock; enable resets 1
// - main clock enable resets to 1 and gates the main clock
// - main select: 00 slow reference, 10 fast, 11 pll; resets to 11
// - fourteen-bit pll feedback divider driven to pll, reset 0x0beb
// - first post divider is value plus one, reset 1; second also driven out, reset 0
// - two power-down bits for post divider and whole pll, reset powered
// - bypass bit sends pll reference straight to both pll outputs
// - force bit takes debug enables from this bank instead of crypto unit
// - debug enable bits drive processor debug inputs with listed resets
// - external interrupt enable and polarity invert bits, both reset 0
// - sram protection interrupt enable and clear bits
// - qspi protection interrupt enable and clear bits
// - peripheral protection interrupt clear resets 1, enable resets 0
// - each core gets a 25-bit secure reset vector, reset 0x0004000
// - main input select routes pad input to main function or alternate
// - main output select takes pad data from main or alternate function
// - main oe select takes pad enable from main or alternate function
// - default input bits drive the unselected input mux side
module scr_system_config_control_regs
	import scr_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int NUM_PINS = 16
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register port
	input wire logic [ADDR_W-1:0] busAddr,
	input wire logic [31:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [31:0] busRdata,
	// clock selection controls
	output logic testClockEnable,
	output logic [2:0] testClockSelect,
	output logic pllInputSelect,
	output logic configClockSelect,
	output logic slowRefClockEnable,
	output logic slowRefClockSelect,
	output logic configClockEnable,
	output logic mainClockEnable,
	output logic [1:0] mainClockSelect,
	output logic clockSelectReserved,
	// pll controls
	output logic [13:0] pllFeedbackDivider,
	output logic [3:0] pllFirstPostDivider,
	output logic [3:0] pllSecondPostDivider,
	output logic firstPostDividerPowerDown,
	output logic pllPowerDown,
	output logic pllBypass,
	// debug enables: {system, secure noninvasive, secure invasive, noninvasive, general}
	input wire logic [4:0] cryptoDebugEnables,
	output logic [4:0] debugEnables,
	output logic [1:0] securityFrequencySelect,
	// interrupts
	input wire logic externalInterruptPin,
	output logic externalIrqOut,
	input wire logic sramProtectIrqIn,
	input wire logic qspiProtectIrqIn,
	input wire logic periphProtectIrqIn,
	output logic sramProtectIrqOut,
	output logic qspiProtectIrqOut,
	output logic periphProtectIrqOut,
	// secure reset vectors
	output logic [24:0] core0SecureResetVector,
	output logic [24:0] core1SecureResetVector,
	// pin multiplexing
	input wire logic [NUM_PINS-1:0] padIn,
	output logic [NUM_PINS-1:0] mainIn,
	output logic [NUM_PINS-1:0] altIn,
	input wire logic [NUM_PINS-1:0] mainOut,
	input wire logic [NUM_PINS-1:0] mainOe,
	input wire logic [NUM_PINS-1:0] altOut,
	input wire logic [NUM_PINS-1:0] altOe,
	output logic [NUM_PINS-1:0] padOut,
	output logic [NUM_PINS-1:0] padOe
);

	typedef struct packed {
		logic [31:0] clk;
		logic [31:0] pll;
		logic [31:0] dbg;
		logic [31:0] intr;
		logic [31:0] vec0;
		logic [31:0] vec1;
		logic [31:0] insel;
		logic [31:0] outsel;
		logic [31:0] oesel;
		logic [31:0] defin;
		logic [31:0] rdata;
		logic extS1;
		logic extS2;
		logic [NUM_PINS-1:0] padS1;
		logic [NUM_PINS-1:0] padS2;
		logic [4:0] dbgOut;
		logic extIrq;
		logic sramIrq;
		logic qspiIrq;
		logic periphIrq;
		logic reserved;
		logic [NUM_PINS-1:0] mainIn;
		logic [NUM_PINS-1:0] altIn;
		logic [NUM_PINS-1:0] padOut;
		logic [NUM_PINS-1:0] padOe;
	} scr_state_s;

	localparam scr_state_s ST_RESET = '{
		clk: CLK_RESET, pll: PLL_RESET, dbg: DBG_RESET, intr: INT_RESET,
		vec0: VEC_RESET, vec1: VEC_RESET, insel: PIN_SELECT_RESET,
		outsel: PIN_SELECT_RESET, oesel: PIN_SELECT_RESET, defin: PIN_DEFAULT_RESET,
		dbgOut: DBG_RESET[4:0], default: '0};

	scr_state_s stReg;
	scr_state_s stNext;
	logic [NUM_PINS-1:0] inSel;
	logic [NUM_PINS-1:0] outSel;
	logic [NUM_PINS-1:0] oeSel;
	logic [NUM_PINS-1:0] defIn;

	function automatic logic [31:0] update(input logic [31:0] old, input logic [31:0] data,
		input logic hit, input logic [31:0] mask);
		return hit ? (data & mask) : old;
	endfunction

	function automatic logic match(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
		return addr == ADDR_W'(ofs);
	endfunction

	assign inSel = stReg.insel[NUM_PINS-1:0];
	assign outSel = stReg.outsel[NUM_PINS-1:0];
	assign oeSel = stReg.oesel[NUM_PINS-1:0];
	assign defIn = stReg.defin[NUM_PINS-1:0];

	always_comb
	begin
		stNext = stReg;
		// masked writes keep reserved bits at zero
		stNext.clk = update(stReg.clk, busWdata, busWrite && match(busAddr, OFS_CLOCK_CONTROL),
			CLK_MASK);
		stNext.pll = update(stReg.pll, busWdata, busWrite && match(busAddr, OFS_PLL_CONTROL),
			PLL_MASK);
		stNext.dbg = update(stReg.dbg, busWdata, busWrite && match(busAddr, OFS_DEBUG_CONTROL),
			DBG_MASK);
		stNext.intr = update(stReg.intr, busWdata,
			busWrite && match(busAddr, OFS_INTERRUPT_CONTROL), INT_MASK);
		stNext.vec0 = update(stReg.vec0, busWdata,
			busWrite && match(busAddr, OFS_CORE0_SECURE_VECTOR), VEC_MASK);
		stNext.vec1 = update(stReg.vec1, busWdata,
			busWrite && match(busAddr, OFS_CORE1_SECURE_VECTOR), VEC_MASK);
		stNext.insel = update(stReg.insel, busWdata,
			busWrite && match(busAddr, OFS_PIN_MAIN_INPUT_SELECT), PIN_MASK);
		stNext.outsel = update(stReg.outsel, busWdata,
			busWrite && match(busAddr, OFS_PIN_MAIN_OUTPUT_SELECT), PIN_MASK);
		stNext.oesel = update(stReg.oesel, busWdata,
			busWrite && match(busAddr, OFS_PIN_MAIN_OE_SELECT), PIN_MASK);
		stNext.defin = update(stReg.defin, busWdata,
			busWrite && match(busAddr, OFS_PIN_MAIN_DEFAULT_INPUT), PIN_MASK);
		// read data stands only in the cycle after the strobe; unmapped reads zero
		stNext.rdata = '0;
		if (busRead)
		begin
			case (busAddr)
				ADDR_W'(OFS_CLOCK_CONTROL): stNext.rdata = stReg.clk;
				ADDR_W'(OFS_PLL_CONTROL): stNext.rdata = stReg.pll;
				ADDR_W'(OFS_DEBUG_CONTROL): stNext.rdata = stReg.dbg;
				ADDR_W'(OFS_INTERRUPT_CONTROL): stNext.rdata = stReg.intr;
				ADDR_W'(OFS_CORE0_SECURE_VECTOR): stNext.rdata = stReg.vec0;
				ADDR_W'(OFS_CORE1_SECURE_VECTOR): stNext.rdata = stReg.vec1;
				ADDR_W'(OFS_PIN_MAIN_INPUT_SELECT): stNext.rdata = stReg.insel;
				ADDR_W'(OFS_PIN_MAIN_OUTPUT_SELECT): stNext.rdata = stReg.outsel;
				ADDR_W'(OFS_PIN_MAIN_OE_SELECT): stNext.rdata = stReg.oesel;
				ADDR_W'(OFS_PIN_MAIN_DEFAULT_INPUT): stNext.rdata = stReg.defin;
				default: stNext.rdata = '0;
			endcase
		end
		// pin synchronisers
		stNext.extS1 = externalInterruptPin;
		stNext.extS2 = stReg.extS1;
		stNext.padS1 = padIn;
		stNext.padS2 = stReg.padS1;
		// flag codes that select reserved clock sources
		stNext.reserved = stReg.clk[CLK_PLL_IN_SEL_BIT]
			|| (stReg.clk[CLK_MAIN_SEL_LSB +: 2] == MAIN_SEL_RESERVED)
			|| !(stReg.clk[CLK_TEST_SEL_LSB +: 3] inside
			{TEST_SEL_VCO, TEST_SEL_CORE, TEST_SEL_SYSTEM, TEST_SEL_CONFIG});
		stNext.dbgOut = stReg.dbg[DBG_FORCE_BIT] ? stReg.dbg[4:0]
			: cryptoDebugEnables;
		stNext.extIrq = (stReg.extS2 & stReg.intr[INT_EXT_EN_BIT])
			^ stReg.intr[INT_EXT_INV_BIT];
		// a set clear bit holds its interrupt low
		stNext.sramIrq = sramProtectIrqIn & stReg.intr[INT_SRAM_EN_BIT]
			& ~stReg.intr[INT_SRAM_CLR_BIT];
		stNext.qspiIrq = qspiProtectIrqIn & stReg.intr[INT_QSPI_EN_BIT]
			& ~stReg.intr[INT_QSPI_CLR_BIT];
		stNext.periphIrq = periphProtectIrqIn & stReg.intr[INT_PERIPH_EN_BIT]
			& ~stReg.intr[INT_PERIPH_CLR_BIT];
		// unselected side of the input mux takes the default level
		stNext.mainIn = (inSel & stReg.padS2) | (~inSel & defIn);
		stNext.altIn = (~inSel & stReg.padS2) | (inSel & defIn);
		stNext.padOut = (outSel & mainOut) | (~outSel & altOut);
		stNext.padOe = (oeSel & mainOe) | (~oeSel & altOe);
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			stReg <= ST_RESET;
		else
			stReg <= stNext;
	end

	assign busRdata = stReg.rdata;
	assign testClockEnable = stReg.clk[CLK_TEST_EN_BIT];
	assign testClockSelect = stReg.clk[CLK_TEST_SEL_LSB +: 3];
	assign pllInputSelect = stReg.clk[CLK_PLL_IN_SEL_BIT];
	assign configClockSelect = stReg.clk[CLK_CFG_SEL_BIT];
	assign slowRefClockEnable = stReg.clk[CLK_REF_EN_BIT];
	assign slowRefClockSelect = stReg.clk[CLK_REF_SEL_BIT];
	assign configClockEnable = stReg.clk[CLK_CFG_EN_BIT];
	assign mainClockEnable = stReg.clk[CLK_MAIN_EN_BIT];
	assign mainClockSelect = stReg.clk[CLK_MAIN_SEL_LSB +: 2];
	assign clockSelectReserved = stReg.reserved;
	assign pllFeedbackDivider = stReg.pll[PLL_FB_LSB +: 14];
	assign pllFirstPostDivider = stReg.pll[PLL_POST1_LSB +: 4];
	assign pllSecondPostDivider = stReg.pll[PLL_POST2_LSB +: 4];
	assign firstPostDividerPowerDown = stReg.pll[PLL_POST1_OFF_BIT];
	assign pllPowerDown = stReg.pll[PLL_OFF_BIT];
	assign pllBypass = stReg.pll[PLL_BYPASS_BIT];
	assign debugEnables = stReg.dbgOut;
	assign securityFrequencySelect = stReg.dbg[DBG_FREQ_LSB +: 2];
	assign externalIrqOut = stReg.extIrq;
	assign sramProtectIrqOut = stReg.sramIrq;
	assign qspiProtectIrqOut = stReg.qspiIrq;
	assign periphProtectIrqOut = stReg.periphIrq;
	assign core0SecureResetVector = stReg.vec0[VEC_LSB +: 25];
	assign core1SecureResetVector = stReg.vec1[VEC_LSB +: 25];
	assign mainIn = stReg.mainIn;
	assign altIn = stReg.altIn;
	assign padOut = stReg.padOut;
	assign padOe = stReg.padOe;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_write_clk;
		busWrite && match(busAddr, OFS_CLOCK_CONTROL);
	endsequence
	sequence s_read_clk;
		busRead && match(busAddr, OFS_CLOCK_CONTROL);
	endsequence

	property p_clk_write;
		s_write_clk |=> testClockSelect == $past(busWdata[14:12])
			&& mainClockSelect == $past(busWdata[1:0]) && testClockEnable == $past(busWdata[15]);
	endproperty
	a_clk_write: assert property (p_clk_write) else $error("clock control not updated");

	property p_reserved;
		(mainClockSelect == MAIN_SEL_RESERVED || pllInputSelect
			|| testClockSelect == 3'h3) |=> clockSelectReserved;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved select not flagged");

	property p_pll_write;
		busWrite && match(busAddr, OFS_PLL_CONTROL) |=>
			pllFeedbackDivider == $past(busWdata[29:16]) && pllBypass == $past(busWdata[1]);
	endproperty
	a_pll_write: assert property (p_pll_write) else $error("pll control not updated");

	property p_pll_hold;
		!(busWrite && match(busAddr, OFS_PLL_CONTROL)) |=>
			$stable(pllFirstPostDivider) && $stable(pllPowerDown)
			&& $stable(firstPostDividerPowerDown);
	endproperty
	a_pll_hold: assert property (p_pll_hold) else $error("pll control changed unbidden");

	property p_debug_source;
		stReg.dbg[DBG_FORCE_BIT] |=> debugEnables == $past(stReg.dbg[4:0]);
	endproperty
	a_debug_source: assert property (p_debug_source) else $error("debug not forced");

	property p_debug_crypto;
		!stReg.dbg[DBG_FORCE_BIT] |=> debugEnables == $past(cryptoDebugEnables);
	endproperty
	a_debug_crypto: assert property (p_debug_crypto) else $error("debug not from crypto");

	property p_ext_irq;
		($stable(externalInterruptPin) && $stable(stReg.intr)) [*4] |->
			externalIrqOut == ((externalInterruptPin & stReg.intr[INT_EXT_EN_BIT])
			^ stReg.intr[INT_EXT_INV_BIT]);
	endproperty
	a_ext_irq: assert property (p_ext_irq) else $error("external irq wrong");

	property p_sram_irq;
		1'b1 |=> sramProtectIrqOut == $past(sramProtectIrqIn & stReg.intr[INT_SRAM_EN_BIT]
			& ~stReg.intr[INT_SRAM_CLR_BIT]);
	endproperty
	a_sram_irq: assert property (p_sram_irq) else $error("sram irq wrong");

	property p_qspi_irq;
		qspiProtectIrqIn && stReg.intr[INT_QSPI_EN_BIT] && !stReg.intr[INT_QSPI_CLR_BIT]
			|=> qspiProtectIrqOut;
	endproperty
	a_qspi_irq: assert property (p_qspi_irq) else $error("qspi irq lost");

	property p_periph_clear;
		stReg.intr[INT_PERIPH_CLR_BIT] [*2] |-> !periphProtectIrqOut;
	endproperty
	a_periph_clear: assert property (p_periph_clear) else $error("periph irq not cleared");

	property p_vector;
		busWrite && match(busAddr, OFS_CORE0_SECURE_VECTOR) |=>
			core0SecureResetVector == $past(busWdata[31:7]) && $stable(core1SecureResetVector);
	endproperty
	a_vector: assert property (p_vector) else $error("core vector wrong");

	property p_pin_in;
		1'b1 |=> mainIn == $past((inSel & stReg.padS2) | (~inSel & defIn));
	endproperty
	a_pin_in: assert property (p_pin_in) else $error("main input mux wrong");

	property p_pin_out;
		1'b1 |=> padOut == $past((outSel & mainOut) | (~outSel & altOut))
			&& padOe == $past((oeSel & mainOe) | (~oeSel & altOe));
	endproperty
	a_pin_out: assert property (p_pin_out) else $error("pad output mux wrong");

	property p_read_idle;
		!busRead |=> busRdata == 32'h0000_0000;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not zero");

	property p_readback;
		s_write_clk ##1 s_read_clk |=> busRdata == ($past(busWdata, 2) & CLK_MASK);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

endmodule

// ---- tb/scr_testbench.sv ----
// self-checking bench for the configuration register bank
// assumes the bank's register port, reset values and output latencies as handed over
module testbench
	import scr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, reset_n, busWrite, busRead, externalInterruptPin;
	logic [7:0] busAddr;
	logic [31:0] busWdata, busRdata;
	logic testClockEnable, pllInputSelect, configClockSelect, slowRefClockEnable;
	logic slowRefClockSelect, configClockEnable, mainClockEnable, clockSelectReserved;
	logic [2:0] testClockSelect;
	logic [1:0] mainClockSelect, securityFrequencySelect;
	logic [13:0] pllFeedbackDivider;
	logic [3:0] pllFirstPostDivider, pllSecondPostDivider;
	logic firstPostDividerPowerDown, pllPowerDown, pllBypass, externalIrqOut;
	logic [4:0] cryptoDebugEnables, debugEnables;
	logic sramProtectIrqIn, qspiProtectIrqIn, periphProtectIrqIn;
	logic sramProtectIrqOut, qspiProtectIrqOut, periphProtectIrqOut;
	logic [24:0] core0SecureResetVector, core1SecureResetVector;
	logic [15:0] padIn, mainIn, altIn, mainOut, mainOe, altOut, altOe, padOut, padOe;
	int nErrors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] ofs [10] = '{OFS_CLOCK_CONTROL, OFS_PLL_CONTROL, OFS_DEBUG_CONTROL,
		OFS_INTERRUPT_CONTROL, OFS_CORE0_SECURE_VECTOR, OFS_CORE1_SECURE_VECTOR,
		OFS_PIN_MAIN_INPUT_SELECT, OFS_PIN_MAIN_OUTPUT_SELECT, OFS_PIN_MAIN_OE_SELECT,
		OFS_PIN_MAIN_DEFAULT_INPUT};
	logic [31:0] rst [10] = '{32'h0000_0027, 32'h0beb_0100, 32'h0000_001e, 32'h0000_0002,
		32'h0020_0000, 32'h0020_0000, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0};
	logic [31:0] msk [10] = '{32'h0000_f0ff, 32'h3fff_ff07, 32'h8000_07df, 32'h0003_003f,
		32'hffff_ff80, 32'hffff_ff80, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff};
	logic [31:0] cw [4] = '{32'h0000_0001, 32'h0000_0080, 32'h0000_005a, 32'h0000_0000};
	logic [31:0] iw [3] = '{32'h0001_0015, 32'h0000_003f, 32'h0003_0000};
	logic [3:0] ie [3] = '{4'hf, 4'h0, 4'h0};

	scr_system_config_control_regs i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
		.busRdata(busRdata), .testClockEnable(testClockEnable), .testClockSelect(testClockSelect),
		.pllInputSelect(pllInputSelect), .configClockSelect(configClockSelect),
		.slowRefClockEnable(slowRefClockEnable), .slowRefClockSelect(slowRefClockSelect),
		.configClockEnable(configClockEnable), .mainClockEnable(mainClockEnable),
		.mainClockSelect(mainClockSelect), .clockSelectReserved(clockSelectReserved),
		.pllFeedbackDivider(pllFeedbackDivider), .pllFirstPostDivider(pllFirstPostDivider),
		.pllSecondPostDivider(pllSecondPostDivider), .pllPowerDown(pllPowerDown),
		.firstPostDividerPowerDown(firstPostDividerPowerDown), .pllBypass(pllBypass),
		.cryptoDebugEnables(cryptoDebugEnables), .debugEnables(debugEnables),
		.securityFrequencySelect(securityFrequencySelect),
		.externalInterruptPin(externalInterruptPin), .externalIrqOut(externalIrqOut),
		.sramProtectIrqIn(sramProtectIrqIn), .qspiProtectIrqIn(qspiProtectIrqIn),
		.periphProtectIrqIn(periphProtectIrqIn), .sramProtectIrqOut(sramProtectIrqOut),
		.qspiProtectIrqOut(qspiProtectIrqOut), .periphProtectIrqOut(periphProtectIrqOut),
		.core0SecureResetVector(core0SecureResetVector),
		.core1SecureResetVector(core1SecureResetVector), .padIn(padIn), .mainIn(mainIn),
		.altIn(altIn), .mainOut(mainOut), .mainOe(mainOe), .altOut(altOut), .altOe(altOe),
		.padOut(padOut), .padOe(padOe));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busWdata <= d;
		busWrite <= 1'b1;
		@(posedge sys_clk);
		busWrite <= 1'b0;
	endtask
	// read data are taken mid-cycle after the strobe edge
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		busAddr <= a;
		busRead <= 1'b1;
		@(posedge sys_clk);
		busRead <= 1'b0;
		@(negedge sys_clk);
		chk(what, busRdata, exp);
	endtask
	// muxed outputs need two cycles, synchronised pins three
	task automatic settle;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			nErrors++;
			report_and_stop();
		end
	end

	initial
	begin
		reset_n = 1'b0;
		busWrite = 1'b0;
		busRead = 1'b0;
		busAddr = 8'h00;
		busWdata = 32'h0;
		cryptoDebugEnables = 5'h0a;
		externalInterruptPin = 1'b1;
		{sramProtectIrqIn, qspiProtectIrqIn, periphProtectIrqIn} = 3'b111;
		padIn = 16'ha5c3;
		mainOut = 16'h1234;
		altOut = 16'hfedc;
		mainOe = 16'h00ff;
		altOe = 16'hf0f0;
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++)
			rdchk("reset value", ofs[i], rst[i]);
		chk("clock outs", 32'({mainClockEnable, mainClockSelect, slowRefClockEnable}),
			32'hf);
		chk("pll outs", 32'({pllFeedbackDivider, pllFirstPostDivider, pllPowerDown}),
			32'h17d62);
		chk("debug from crypto", 32'(debugEnables), 32'h0a);
		chk("vector reset", 32'(core0SecureResetVector), 32'h0004000);
		for (int i = 0; i < 10; i++)
		begin
			wr(ofs[i], 32'hffff_ffff);
			rdchk("writable bits", ofs[i], msk[i]);
		end
		settle();
		chk("pll all set", 32'({pllFeedbackDivider, firstPostDividerPowerDown, pllBypass,
			pllPowerDown, pllSecondPostDivider, pllFirstPostDivider}), 32'h01ff_ffff);
		chk("debug forced", 32'(debugEnables), 32'h1f);
		chk("irq held clear", 32'({sramProtectIrqOut, qspiProtectIrqOut,
			periphProtectIrqOut}), 32'h0);
		chk("ext inverted", 32'(externalIrqOut), 32'h0);
		wr(8'h08, 32'hffff_ffff);
		rdchk("unmapped", 8'h08, 32'h0);
		rdchk("untouched", OFS_CLOCK_CONTROL, 32'h0000_f0ff);
		for (int c = 0; c < 8; c++)
		begin
			wr(OFS_CLOCK_CONTROL, 32'h0000_8003 | (32'(c) << 12));
			settle();
			chk("test clock", 32'({testClockEnable, testClockSelect}), 32'(8 + c));
			chk("test reserved", 32'(clockSelectReserved), 32'(c inside {3, 4, 6, 7}));
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_CLOCK_CONTROL, cw[i]);
			settle();
			chk("clock bits", 32'({pllInputSelect, configClockSelect, slowRefClockEnable,
				slowRefClockSelect, configClockEnable, mainClockEnable, mainClockSelect}), cw[i]);
			chk("main reserved", 32'(clockSelectReserved), 32'(i < 2));
		end
		wr(OFS_PLL_CONTROL, 32'h1234_5a02);
		settle();
		chk("pll fields", 32'({pllFeedbackDivider, pllSecondPostDivider, pllFirstPostDivider,
			firstPostDividerPowerDown, pllBypass, pllPowerDown}), 32'h0091_a2d2);
		wr(OFS_DEBUG_CONTROL, 32'h8000_00d5);
		settle();
		chk("debug forced", 32'({securityFrequencySelect, debugEnables}), 32'h75);
		@(posedge sys_clk);
		cryptoDebugEnables <= 5'h11;
		wr(OFS_DEBUG_CONTROL, 32'h0000_0015);
		settle();
		chk("debug crypto", 32'(debugEnables), 32'h11);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_INTERRUPT_CONTROL, iw[i]);
			settle();
			chk("irq outs", 32'({externalIrqOut, sramProtectIrqOut, qspiProtectIrqOut,
				periphProtectIrqOut}), 32'(ie[i]));
		end
		wr(OFS_CORE0_SECURE_VECTOR, 32'h1234_56ff);
		rdchk("vector", OFS_CORE0_SECURE_VECTOR, 32'h1234_5680);
		settle();
		chk("core0 vector", 32'(core0SecureResetVector), 32'h1234_5680 >> 7);
		chk("core1 vector", 32'(core1SecureResetVector), 32'h01ff_ffff);
		wr(OFS_PIN_MAIN_INPUT_SELECT, 32'habcd_ff00);
		wr(OFS_PIN_MAIN_OUTPUT_SELECT, 32'h0000_0f0f);
		wr(OFS_PIN_MAIN_OE_SELECT, 32'h0000_3c3c);
		wr(OFS_PIN_MAIN_DEFAULT_INPUT, 32'h0000_0ff0);
		settle();
		chk("main in", 32'(mainIn), 32'h0000_a5f0);
		chk("alt in", 32'(altIn), 32'h0000_0fc3);
		chk("pad out", 32'(padOut), 32'h0000_f2d4);
		chk("pad oe", 32'(padOe), 32'h0000_c0fc);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdchk("second reset", OFS_PLL_CONTROL, 32'h0beb_0100);
		report_and_stop();
	end
endmodule
